// file: design/dual_timer_counter.sv
module dual_timer_counter
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] rdata,
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic ext_gate_pin_zero,
  input wire logic ext_gate_pin_one,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  output logic timer0_div64_out,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag
);
  logic rst_meta;
  logic rst_n;
  logic [7:0] timer_control;
  logic [7:0] timer_mode_select;
  logic [7:0] pin_control;
  logic tick;
  logic [5:0] div_count;
  logic [7:0] low_byte [2];
  logic [7:0] high_byte [2];
  logic [1:0] overflow;
  logic [1:0] vector_ack;
  logic [1:0] gate_pins;
  logic [1:0] count_pins;
  logic [7:0] next_control;
  logic [7:0] next_mode;
  logic [7:0] next_pin_control;
  logic next_tick;
  logic [5:0] next_div_count;
  logic next_div64;
  logic [7:0] next_rdata;
  logic wr_ctrl;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign vector_ack = {timer1_vector_ack, timer0_vector_ack};
  assign gate_pins = {ext_gate_pin_one, ext_gate_pin_zero};
  assign count_pins = {timer1_count_pin, timer0_count_pin};
  assign wr_ctrl = write_strobe && addr == ADDR_TIMER_CONTROL;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      localparam int MB = ch * MODE_CHAN_STRIDE;
      localparam logic [7:0] LOW_ADDR = ch ? ADDR_TIMER1_LOW_BYTE : ADDR_TIMER0_LOW_BYTE;
      localparam logic [7:0] HIGH_ADDR = ch ? ADDR_TIMER1_HIGH_BYTE : ADDR_TIMER0_HIGH_BYTE;
      timer_channel u_chan (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(timer_control[ch ? CTRL_TR1_BIT : CTRL_TR0_BIT]),
        .gating(timer_mode_select[MB + MODE_GATE_BIT]),
        .count_select(timer_mode_select[MB + MODE_SEL_BIT]),
        .mode(timer_mode_t'(timer_mode_select[MB + MODE_FIELD_LSB +: 2])),
        .tick(tick),
        .gate_pin(gate_pins[ch]),
        .count_pin(count_pins[ch]),
        .low_write(write_strobe && addr == LOW_ADDR),
        .high_write(write_strobe && addr == HIGH_ADDR),
        .wdata(wdata),
        .low_byte(low_byte[ch]),
        .high_byte(high_byte[ch]),
        .overflow(overflow[ch])
      );
    end
  endgenerate

  always_comb begin
    next_control = timer_control;
    next_mode = timer_mode_select;
    next_pin_control = pin_control;
    if (wr_ctrl) begin
      next_control = wdata;
    end
    if (write_strobe && addr == ADDR_TIMER_MODE_SELECT) begin
      next_mode = wdata;
    end
    if (write_strobe && addr == ADDR_PIN_CONTROL) begin
      next_pin_control = wdata;
    end
    if (vector_ack[0]) begin
      next_control[CTRL_TF0_BIT] = 1'b0;
    end
    if (vector_ack[1]) begin
      next_control[CTRL_TF1_BIT] = 1'b0;
    end
    // Hardware set wins over any clear in the same cycle
    if (overflow[0]) begin
      next_control[CTRL_TF0_BIT] = 1'b1;
    end
    if (overflow[1]) begin
      next_control[CTRL_TF1_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_tick = (tick == 1'b0);
    next_div_count = div_count;
    next_div64 = timer0_div64_out;
    if (!pin_control[PIN_DIV64_EN_BIT]) begin
      next_div_count = 6'h00;
      next_div64 = 1'b0;
    end else if (overflow[0]) begin
      if (div_count == 6'(DIV64_TOGGLE - 1)) begin
        next_div_count = 6'h00;
        next_div64 = ~timer0_div64_out;
      end else begin
        next_div_count = div_count + 6'h01;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (read_strobe) begin
      unique case (addr)
        ADDR_TIMER_CONTROL: next_rdata = timer_control;
        ADDR_TIMER_MODE_SELECT: next_rdata = timer_mode_select;
        ADDR_TIMER0_LOW_BYTE: next_rdata = low_byte[0];
        ADDR_TIMER1_LOW_BYTE: next_rdata = low_byte[1];
        ADDR_TIMER0_HIGH_BYTE: next_rdata = high_byte[0];
        ADDR_TIMER1_HIGH_BYTE: next_rdata = high_byte[1];
        ADDR_PIN_CONTROL: next_rdata = pin_control;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control <= RESET_BYTE;
      timer_mode_select <= RESET_BYTE;
      pin_control <= RESET_BYTE;
      tick <= 1'b0;
      div_count <= 6'h00;
      timer0_div64_out <= 1'b0;
      rdata <= 8'h00;
    end else begin
      timer_control <= next_control;
      timer_mode_select <= next_mode;
      pin_control <= next_pin_control;
      tick <= next_tick;
      div_count <= next_div_count;
      timer0_div64_out <= next_div64;
      rdata <= next_rdata;
    end
  end

  assign timer0_overflow_flag = timer_control[CTRL_TF0_BIT];
  assign timer1_overflow_flag = timer_control[CTRL_TF1_BIT];

  // Time base and timer0 overflow spacing
  a_tick_alternates: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick
    |=> !tick ##1 tick)
    else $error("time base not every 2 clocks");
  a_ov0_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow[0]
    |=> !overflow[0])
    else $error("timer0 overflow on two cycles in a row");

  // Overflow flags
  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow[0]
    |=> timer0_overflow_flag)
    else $error("timer0 flag not set");
  a_flag1_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow[1]
    |=> timer1_overflow_flag)
    else $error("timer1 flag not set");
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timer0_vector_ack && !overflow[0])
    |=> !timer0_overflow_flag)
    else $error("timer0 flag not cleared");
  a_flag1_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (timer1_vector_ack && !overflow[1])
    |=> !timer1_overflow_flag)
    else $error("timer1 flag not cleared");
  a_flag0_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!timer0_vector_ack && !overflow[0] && !wr_ctrl)
    |=> $stable(timer0_overflow_flag))
    else $error("timer0 flag changed without cause");
  a_flag1_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!timer1_vector_ack && !overflow[1] && !wr_ctrl)
    |=> $stable(timer1_overflow_flag))
    else $error("timer1 flag changed without cause");
  a_ov0_needs_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow[0]
    |-> $past(timer_control[CTRL_TR0_BIT]))
    else $error("timer0 overflowed while stopped");
  a_ov1_needs_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overflow[1]
    |-> $past(timer_control[CTRL_TR1_BIT]))
    else $error("timer1 overflowed while stopped");

  // Register writes
  a_run0_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_ctrl
    |=> $stable(timer_control[CTRL_TR0_BIT]))
    else $error("timer0 run bit changed without write");
  a_run1_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_ctrl
    |=> $stable(timer_control[CTRL_TR1_BIT]))
    else $error("timer1 run bit changed without write");
  a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && !timer0_vector_ack && !timer1_vector_ack && overflow == 2'b00)
    |=> (timer_control == $past(wdata)))
    else $error("control write lost");
  a_mode_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (write_strobe && addr == ADDR_TIMER_MODE_SELECT)
    |=> (timer_mode_select == $past(wdata)))
    else $error("mode write lost");
  a_mode_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(write_strobe && addr == ADDR_TIMER_MODE_SELECT)
    |=> $stable(timer_mode_select))
    else $error("mode changed without write");
  a_pin_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (write_strobe && addr == ADDR_PIN_CONTROL)
    |=> (pin_control == $past(wdata)))
    else $error("pin control write lost");
  a_pin_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(write_strobe && addr == ADDR_PIN_CONTROL)
    |=> $stable(pin_control))
    else $error("pin control changed without write");

  // Read path
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !read_strobe
    |=> (rdata == 8'h00))
    else $error("read data not zero outside a read");
  a_read_control: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_TIMER_CONTROL)
    |=> (rdata == $past(timer_control)))
    else $error("control read wrong");
  a_read_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_TIMER_MODE_SELECT)
    |=> (rdata == $past(timer_mode_select)))
    else $error("mode read wrong");
  a_read_t0_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_TIMER0_LOW_BYTE)
    |=> (rdata == $past(low_byte[0])))
    else $error("timer0 low byte read wrong");
  a_read_t1_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_TIMER1_LOW_BYTE)
    |=> (rdata == $past(low_byte[1])))
    else $error("timer1 low byte read wrong");
  a_read_t0_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_TIMER0_HIGH_BYTE)
    |=> (rdata == $past(high_byte[0])))
    else $error("timer0 high byte read wrong");
  a_read_t1_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_TIMER1_HIGH_BYTE)
    |=> (rdata == $past(high_byte[1])))
    else $error("timer1 high byte read wrong");
  a_read_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (read_strobe && addr == ADDR_PIN_CONTROL)
    |=> (rdata == $past(pin_control)))
    else $error("pin control read wrong");

  // Divided output
  a_div_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pin_control[PIN_DIV64_EN_BIT]
    |=> !timer0_div64_out)
    else $error("divided output active while disabled");
  a_div_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n
    |-> (div_count < 6'(DIV64_TOGGLE)))
    else $error("divider count out of range");
  a_div_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_control[PIN_DIV64_EN_BIT] && overflow[0] && div_count == 6'(DIV64_TOGGLE - 1))
    |=> (timer0_div64_out != $past(timer0_div64_out)))
    else $error("divided output missed its toggle");
  a_div_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_control[PIN_DIV64_EN_BIT] && !overflow[0])
    |=> $stable(timer0_div64_out))
    else $error("divided output moved without overflow");
  a_div_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_control[PIN_DIV64_EN_BIT] && overflow[0] && div_count != 6'(DIV64_TOGGLE - 1))
    |=> (div_count == $past(div_count) + 6'h01))
    else $error("divider count did not step");

  // Main scenarios
  c_flag0: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(timer0_overflow_flag));
  c_flag1: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(timer1_overflow_flag));
  c_div_out: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(timer0_div64_out));
endmodule

// file: design/dual_timer_pkg.sv
// Functional notes
// - Timer mode advances an enabled counter once every 2 system clocks.
// - When enabled, output pin toggles timer0 overflows divided by 64.
// - Each channel count lives in a low byte and a high byte.
// - Hardware sets overflow flag bit 7 (timer1) or bit 5 (timer0).
// - Overflow flag clears when the processor vectors into that interrupt.
// - Run bit 6 (timer1) or bit 4 (timer0): 0 stops, 1 runs.
// - Gating bit set: count only while gate pin high and run bit set.
// - Count select 0 picks two-clock base; 1 counts count-pin falling edges.
// - Mode 00: high byte 8-bit counter behind 5-bit prescaler in low byte.
// - Mode 01: low and high bytes form one 16-bit counter.
// - Mode 10: low byte counts, reloads from high byte on overflow.
// - Mode 11 stops either channel regardless of run bit.
package dual_timer_pkg;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LOW_BYTE = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_LOW_BYTE = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_HIGH_BYTE = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_HIGH_BYTE = 8'h8D;
  localparam logic [7:0] ADDR_PIN_CONTROL = 8'hA6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CTRL_TF1_BIT = 7;
  localparam int CTRL_TR1_BIT = 6;
  localparam int CTRL_TF0_BIT = 5;
  localparam int CTRL_TR0_BIT = 4;
  localparam int PIN_DIV64_EN_BIT = 0;
  // Per-channel field offsets inside the mode byte (channel 1 adds 4)
  localparam int MODE_GATE_BIT = 3;
  localparam int MODE_SEL_BIT = 2;
  localparam int MODE_FIELD_LSB = 0;
  localparam int MODE_CHAN_STRIDE = 4;
  localparam int TICK_DIV = 2;
  localparam int DIV64_TOGGLE = 32;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;
  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'b00,
    MODE_SIXTEEN = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_STOPPED = 2'b11
  } timer_mode_t;
endpackage

// file: design/timer_channel.sv
module timer_channel
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic gating,
  input wire logic count_select,
  input wire dual_timer_pkg::timer_mode_t mode,
  input wire logic tick,
  input wire logic gate_pin,
  input wire logic count_pin,
  input wire logic low_write,
  input wire logic high_write,
  input wire logic [7:0] wdata,
  output logic [7:0] low_byte,
  output logic [7:0] high_byte,
  output logic overflow
);
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic fall;
  logic enabled;
  logic step;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic next_overflow;

  assign fall = pin_prev & ~pin_sync;
  assign enabled = run & (~gating | gate_pin) & (mode != MODE_STOPPED);
  assign step = enabled & (count_select ? fall : tick);

  always_comb begin
    next_low = low_byte;
    next_high = high_byte;
    next_overflow = 1'b0;
    if (step) begin
      unique case (mode)
        MODE_PRESCALED: begin
          if (low_byte[4:0] == PRESCALE_MAX) begin
            next_low = {low_byte[7:5], 5'h00};
            next_high = high_byte + 8'h01;
            next_overflow = (high_byte == 8'hFF);
          end else begin
            next_low = low_byte + 8'h01;
          end
        end
        MODE_SIXTEEN: begin
          {next_high, next_low} = {high_byte, low_byte} + 16'h0001;
          next_overflow = ({high_byte, low_byte} == 16'hFFFF);
        end
        MODE_RELOAD: begin
          if (low_byte == 8'hFF) begin
            next_low = high_byte;
            next_overflow = 1'b1;
          end else begin
            next_low = low_byte + 8'h01;
          end
        end
        MODE_STOPPED: begin
          next_overflow = 1'b0;
        end
      endcase
    end
    if (low_write) begin
      next_low = wdata;
    end
    if (high_write) begin
      next_high = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
      low_byte <= RESET_BYTE;
      high_byte <= RESET_BYTE;
      overflow <= 1'b0;
    end else begin
      pin_meta <= count_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      low_byte <= next_low;
      high_byte <= next_high;
      overflow <= next_overflow;
    end
  end

  a_stop_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!run && !low_write && !high_write) |=> $stable({high_byte, low_byte}))
    else $error("counter moved while stopped");
  a_sixteen_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step && mode == MODE_SIXTEEN && !low_write && !high_write) |=>
    ({high_byte, low_byte} == $past({high_byte, low_byte}) + 16'h0001))
    else $error("16-bit step wrong");
  a_reload_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step && mode == MODE_RELOAD && low_byte == 8'hFF && !low_write) |=>
    (low_byte == $past(high_byte) && overflow))
    else $error("reload wrong");
  a_stop_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE_STOPPED) |=> !overflow)
    else $error("overflow in stopped mode");
  a_gate_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (gating && !gate_pin) |-> !step)
    else $error("counted with gate low");
  c_reload: cover property (@(posedge sys_clk) disable iff (!rst_n)
    step && mode == MODE_RELOAD && overflow);
  c_counter_edge: cover property (@(posedge sys_clk) disable iff (!rst_n)
    count_select && step);
endmodule

// file: test/pin_source.sv
// Far-side count pin: idles high, each pulse is low then high for HOLD cycles
module pin_source #(
  parameter int HOLD = 3
) (
  input wire logic sys_clk,
  input wire logic fire,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  assign busy = (cnt != 0);
  // Low for HOLD cycles, then high for HOLD cycles
  assign pin = !(cnt > HOLD);
  always @(posedge sys_clk) begin
    if (cnt == 0 && fire) begin
      cnt <= 2 * HOLD;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// file: test/tb_dual_timer_counter.sv
module tb_dual_timer_counter;
  import dual_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, arst_n = 0, wst = 0, rst = 0, ack0 = 0, ack1 = 0;
  logic g0 = 0, g1 = 0, fire = 0, p0, p1, b0, b1, out64, tf0, tf1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, st;
  int n_errors = 0, n_checks = 0, seed = 50, i;
  dual_timer_counter dual_timer_counter_i (.sys_clk(sys_clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .write_strobe(wst), .read_strobe(rst), .rdata(rdata),
    .timer0_vector_ack(ack0), .timer1_vector_ack(ack1), .ext_gate_pin_zero(g0),
    .ext_gate_pin_one(g1), .timer0_count_pin(p0), .timer1_count_pin(p1),
    .timer0_div64_out(out64), .timer0_overflow_flag(tf0), .timer1_overflow_flag(tf1));
  pin_source #(.HOLD(3)) pin_source_i (.sys_clk(sys_clk), .fire(fire), .pin(p0), .busy(b0));
  pin_source #(.HOLD(5)) pin_slow_i (.sys_clk(sys_clk), .fire(fire), .pin(p1), .busy(b1));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic int after(input int start, input int cyc);
    return start + cyc / TICK_DIV;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol = 0);
    n_checks++;
    if ((^got === 1'bx) || got > exp + tol || got + tol < exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wst <= 1'b1;
    @(posedge sys_clk);
    wst <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_flag(input logic ch);
    for (i = 0; i < 600 && (ch ? tf1 : tf0) !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(ch ? tf1 : tf0, 16'h1);
    if (i >= 600) results();
  endtask
  task automatic ack(input logic ch);
    chk(ch ? tf1 : tf0, 16'h1);
    @(posedge sys_clk);
    ack0 <= !ch;
    ack1 <= ch;
    @(posedge sys_clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(posedge sys_clk);
    #1 chk(ch ? tf1 : tf0, 16'h0);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(ADDR_TIMER_CONTROL); chk(d, 16'h00);
    rd(ADDR_TIMER_MODE_SELECT); chk(d, 16'h00);
    rd(8'h55); chk(d, 16'h00);
    st = 8'($random(seed)) & 8'h7F;
    wr(8'h8A, st); wr(8'h8C, 8'h00); wr(8'h89, 8'h01); wr(8'h88, 8'h10);
    repeat (40) @(posedge sys_clk);
    wr(8'h88, 8'h00);
    rd(8'h8A); chk(d, after(st, 40), 1);
    wr(8'h8A, 8'hFE); wr(8'h8C, 8'hFF); wr(8'h88, 8'h10);
    wait_flag(0);
    rd(8'h88); chk(d & 8'h30, 16'h30);
    wr(8'h88, 8'h20);
    rd(8'h8C); chk(d, 16'h00);
    ack(0);
    st = (8'($random(seed)) & 8'h3F) | 8'h40;
    wr(8'h8B, 8'hFE); wr(8'h8D, st); wr(8'h89, 8'h20); wr(8'h88, 8'h40);
    wait_flag(1);
    wr(8'h88, 8'h80);
    rd(8'h8B); chk(d, st + 1, 1);
    ack(1);
    wr(8'h8A, 8'h00); wr(8'h8B, 8'h00); wr(8'h89, 8'h33); wr(8'h88, 8'h50);
    repeat (20) @(posedge sys_clk);
    rd(8'h8A); chk(d, 16'h00);
    rd(8'h8B); chk(d, 16'h00);
    wr(8'h8A, 8'hFE); wr(8'h8C, 8'hFF); wr(8'h89, 8'h00); wr(8'h88, 8'h10);
    wait_flag(0);
    wr(8'h88, 8'h20);
    rd(8'h8C); chk(d, 16'h00);
    rd(8'h8A); chk(d & 8'hE0, 16'hE0);
    ack(0);
    wr(8'h8A, 8'h00); wr(8'h8B, 8'h00); wr(8'h89, 8'h99); wr(8'h88, 8'h50);
    repeat (20) @(posedge sys_clk);
    rd(8'h8A); chk(d, 16'h00);
    rd(8'h8B); chk(d, 16'h00);
    g0 <= 1'b1;
    g1 <= 1'b1;
    repeat (20) @(posedge sys_clk);
    wr(8'h88, 8'h00);
    rd(8'h8A); chk(d, after(0, 20), 2);
    rd(8'h8B); chk(d, after(0, 20), 2);
    wr(8'h8A, 8'h00); wr(8'h8B, 8'h00); wr(8'h89, 8'h55); wr(8'h88, 8'h50);
    st = 8'd3 + (8'($random(seed)) & 8'h03);
    repeat (st) begin
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      @(posedge sys_clk);
      for (i = 0; i < 50 && (b0 || b1); i++) @(posedge sys_clk);
      chk(16'(i >= 50), 16'h0);
      if (i >= 50) results();
    end
    repeat (8) @(posedge sys_clk);
    rd(8'h8A); chk(d, st);
    rd(8'h8B); chk(d, st);
    chk(out64, 16'h0);
    wr(ADDR_PIN_CONTROL, 8'h01); wr(8'h8C, 8'hFF); wr(8'h8A, 8'hFF);
    wr(8'h89, 8'h02); wr(8'h88, 8'h10);
    for (i = 0; i < 200 && out64 !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(i, DIV64_TOGGLE * TICK_DIV, 4);
    chk(tf0, 16'h1);
    results();
  end
endmodule
